// ### verilog/gpc_map.vh
// Purpose: register offsets, field positions and reset values of the converter control
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes: definitions only
`ifndef GPC_MAP_VH
`define GPC_MAP_VH
`define GPC_OFS_CTRL 12'h000
`define GPC_OFS_CTRL2 12'h004
`define GPC_OFS_SETTLE 12'h008
`define GPC_OFS_RESULT 12'h00c
`define GPC_OFS_FIFO 12'h010
`define GPC_OFS_STATUS 12'h014
`define GPC_CTRL_EN 0
`define GPC_CTRL_START 1
`define GPC_CTRL_CONT 2
`define GPC_CTRL_SE 3
`define GPC_CTRL_FLAG 4
`define GPC_CTRL_MASK 5
`define GPC_CTRL_DMA 6
`define GPC_CTRL_CH_LO 8
`define GPC_CTRL2_ATT_LO 0
`define GPC_CTRL2_NEG_LO 4
`define GPC_ST_READY 0
`define GPC_ST_BUSY 1
`define GPC_ST_EMPTY 2
`define GPC_ST_FULL 3
`define GPC_ST_LVL_LO 4
`define GPC_RST_SETTLE 8'h40
`define GPC_RST_CH 4'h0
`define GPC_RST_ATT 2'h0
`define GPC_SETTLE_UNIT 2'h3
`define GPC_CH_LAST 4'hd
`endif

// ### verilog/gpc_fifo.v
// Purpose: result buffer between converter and bus/DMA side
// Assumes: single clock, synchronous active high reset
// Notes: no write when full, no read when empty
`timescale 1ns/100ps
module gpc_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire ref_clk,
  input wire rst,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData,
  output wire [AW:0] level
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr;
  reg [AW-1:0] rdPtr;
  reg [AW:0] count;
  wire doWrite;
  wire doRead;

  assign inReady = (count != DEPTH[AW:0]);
  assign outValid = (count != {(AW+1){1'b0}});
  assign doWrite = inValid & inReady;
  assign doRead = outValid & outReady;
  assign outData = mem[rdPtr];
  assign level = count;

  always @(posedge ref_clk) begin
    if (doWrite) begin
      mem[wrPtr] <= inData;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      wrPtr <= {AW{1'b0}};
      rdPtr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr <= (wrPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= (rdPtr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rdPtr + 1'b1;
      end
      if (doWrite && !doRead) begin
        count <= count + 1'b1;
      end else if (doRead && !doWrite) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ### verilog/gpc_adc_ctrl.v
// Purpose: control front-end of a 10-bit converter: channel mux, mode, regulator, results
// Assumes: ref_clk serves as converter and APB clock; analog done/data are asynchronous
// Notes: results go to the newest-value register and to an 8-word buffer for DMA
//
// How it works
// - sequencing logic runs on the converter clock
// - enable bit drives the regulator on/off
// - two-bit attenuation field picks 1x..4x
// - mode bit: 1 single-ended, 0 differential
// - maskable interrupt and separate DMA request
// - pin channels usable single-ended or paired
// - internal sources single-ended or against pin
// - channel code maps to pins/rails/sensor/ground
// - all registers reached over APB slave
// - regulator first, then (settle delay + 1) x4 clocks
// - completion clears start unless continuous, sets flag, stores result
// - start reads 1 until the result is stored, relaunch ignored until then
// - continuous mode restarts after each result
//
// The address map and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "gpc_map.vh"
module gpc_adc_ctrl #(
  parameter DATA_W = 10,
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire regulatorEnable,
  output wire converterReady,
  output wire convStart,
  input wire convDone,
  input wire [DATA_W-1:0] convData,
  output reg [13:0] posSelect,
  output reg [13:0] negSelect,
  output wire [1:0] inputAttenuation,
  output wire singleEndedSelect,
  output wire irq,
  output wire dmaReq
);
  localparam S_OFF = 3'd0;
  localparam S_SETTLE = 3'd1;
  localparam S_IDLE = 3'd2;
  localparam S_CONV = 3'd3;
  localparam S_RELEASE = 3'd4;

  // channel codes: 0..3 and 10..13 pins, 4 temp, 5 converter rail, 6 battery,
  // 7 core supply, 8 analog ground (test), 9 io supply
  function [13:0] decodeChannel;
    input [3:0] code;
    begin
      decodeChannel = 14'h0000;
      if (code <= `GPC_CH_LAST) begin
        decodeChannel[code] = 1'b1;
      end
    end
  endfunction

  function isPinChannel;
    input [3:0] code;
    begin
      isPinChannel = (code <= 4'h3) || ((code >= 4'ha) && (code <= `GPC_CH_LAST));
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // registers
  reg converterEnable;
  reg conversionStart;
  reg continuousConvert;
  reg singleEnded;
  reg doneFlag;
  reg irqMask;
  reg dmaEnable;
  reg [3:0] channelSel;
  reg [3:0] negChannelSel;
  reg [1:0] attenuation;
  reg [7:0] settleDelay;
  reg [DATA_W-1:0] conversionResult;
  reg [2:0] state;
  reg [2:0] next_state;
  reg [1:0] prescale;
  reg [7:0] settleCount;
  reg [2:0] doneSync;
  reg doneLevel;
  reg [DATA_W-1:0] dataSync1;
  reg [DATA_W-1:0] dataSync2;
  reg [DATA_W-1:0] dataSync3;
  reg errFlag;

  wire setupPhase;
  wire accessWrite;
  wire accessRead;
  wire settleTick;
  wire finishConv;
  wire launchConv;
  wire fifoInReady;
  wire fifoOutValid;
  wire fifoPop;
  wire [DATA_W-1:0] fifoOutData;
  wire [FIFO_AW:0] fifoLevel;
  wire flagClear;
  wire startWrite;

  assign setupPhase = psel & ~penable;
  assign accessWrite = psel & penable & pwrite;
  assign accessRead = psel & penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = psel & penable & errFlag;

  ////////////////////////////////////////////////////////////////////////////
  // analog done / data come from the core's own clock; three stages each
  always @(posedge ref_clk) begin
    if (rst) begin
      doneSync <= 3'b000;
      doneLevel <= 1'b0;
      dataSync1 <= {DATA_W{1'b0}};
      dataSync2 <= {DATA_W{1'b0}};
      dataSync3 <= {DATA_W{1'b0}};
    end else begin
      doneSync <= {doneSync[1:0], convDone};
      if (doneSync[1] == doneSync[2]) begin
        doneLevel <= doneSync[2];
      end
      dataSync1 <= convData;
      dataSync2 <= dataSync1;
      dataSync3 <= dataSync2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer
  // settle unit pulse: one in four clocks
  assign settleTick = (prescale == `GPC_SETTLE_UNIT);
  // data is held by the core while done is high, so sampling here is safe
  assign finishConv = (state == S_CONV) && doneLevel;
  // a full buffer stalls new conversions so no result is dropped
  assign launchConv = (state == S_IDLE) && conversionStart && fifoInReady;

  always @* begin
    next_state = state;
    case (state)
      S_OFF: begin
        if (converterEnable) begin
          next_state = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (settleTick && (settleCount >= settleDelay)) begin
          next_state = S_IDLE;
        end
      end
      S_IDLE: begin
        if (launchConv) begin
          next_state = S_CONV;
        end
      end
      S_CONV: begin
        if (finishConv) begin
          next_state = S_RELEASE;
        end
      end
      S_RELEASE: begin
        if (!doneLevel) begin
          next_state = S_IDLE;
        end
      end
      default: begin
        next_state = S_OFF;
      end
    endcase
    if (!converterEnable) begin
      next_state = S_OFF;
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      state <= S_OFF;
      prescale <= 2'b00;
      settleCount <= 8'h00;
    end else begin
      state <= next_state;
      if (state == S_SETTLE) begin
        prescale <= prescale + 2'b01;
        if (settleTick && (settleCount != 8'hff)) begin
          settleCount <= settleCount + 8'h01;
        end
      end else begin
        prescale <= 2'b00;
        settleCount <= 8'h00;
      end
    end
  end

  assign regulatorEnable = converterEnable;
  assign converterReady = (state != S_OFF) && (state != S_SETTLE);
  assign convStart = (state == S_CONV);

  ////////////////////////////////////////////////////////////////////////////
  // analog selection
  always @* begin
    posSelect = decodeChannel(channelSel);
    negSelect = 14'h0000;
    if (!singleEnded && isPinChannel(negChannelSel) && (channelSel != negChannelSel)) begin
      // pins pair with pins, internal sources pair with a pin
      negSelect = decodeChannel(negChannelSel);
    end
  end

  assign singleEndedSelect = singleEnded;
  assign inputAttenuation = attenuation;

  ////////////////////////////////////////////////////////////////////////////
  // result buffer and events
  assign fifoPop = accessRead && (paddr == `GPC_OFS_FIFO);

  gpc_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .inValid(finishConv),
    .inReady(fifoInReady),
    .inData(dataSync3),
    .outValid(fifoOutValid),
    .outReady(fifoPop),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  assign irq = doneFlag & irqMask;
  assign dmaReq = dmaEnable & fifoOutValid;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign flagClear = accessWrite && (paddr == `GPC_OFS_CTRL) && pwdata[`GPC_CTRL_FLAG];
  assign startWrite = accessWrite && (paddr == `GPC_OFS_CTRL) && pwdata[`GPC_CTRL_START];

  always @(posedge ref_clk) begin
    if (rst) begin
      converterEnable <= 1'b0;
      continuousConvert <= 1'b0;
      singleEnded <= 1'b0;
      irqMask <= 1'b0;
      dmaEnable <= 1'b0;
      channelSel <= `GPC_RST_CH;
      negChannelSel <= `GPC_RST_CH;
      attenuation <= `GPC_RST_ATT;
      settleDelay <= `GPC_RST_SETTLE;
    end else if (accessWrite) begin
      case (paddr)
        `GPC_OFS_CTRL: begin
          converterEnable <= pwdata[`GPC_CTRL_EN];
          continuousConvert <= pwdata[`GPC_CTRL_CONT];
          singleEnded <= pwdata[`GPC_CTRL_SE];
          irqMask <= pwdata[`GPC_CTRL_MASK];
          dmaEnable <= pwdata[`GPC_CTRL_DMA];
          channelSel <= pwdata[`GPC_CTRL_CH_LO+3:`GPC_CTRL_CH_LO];
        end
        `GPC_OFS_CTRL2: begin
          attenuation <= pwdata[`GPC_CTRL2_ATT_LO+1:`GPC_CTRL2_ATT_LO];
          negChannelSel <= pwdata[`GPC_CTRL2_NEG_LO+3:`GPC_CTRL2_NEG_LO];
        end
        `GPC_OFS_SETTLE: begin
          settleDelay <= pwdata[7:0];
        end
        default: begin
          settleDelay <= settleDelay;
        end
      endcase
    end
  end

  // start: set only by software when idle-ready, cleared by completion unless continuous, or by a low enable bit
  always @(posedge ref_clk) begin
    if (rst) begin
      conversionStart <= 1'b0;
    end else if (!converterEnable) begin
      conversionStart <= 1'b0;
    end else if (finishConv) begin
      conversionStart <= continuousConvert;
    end else if (startWrite && !conversionStart && converterReady) begin
      conversionStart <= 1'b1;
    end
  end

  // set beats a clear that lands in the same cycle
  always @(posedge ref_clk) begin
    if (rst) begin
      doneFlag <= 1'b0;
      conversionResult <= {DATA_W{1'b0}};
    end else begin
      if (finishConv) begin
        doneFlag <= 1'b1;
        conversionResult <= dataSync3;
      end else if (flagClear) begin
        doneFlag <= 1'b0;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
      errFlag <= 1'b0;
    end else if (setupPhase) begin
      prdata <= 32'h00000000;
      errFlag <= 1'b0;
      case (paddr)
        `GPC_OFS_CTRL: begin
          prdata[`GPC_CTRL_EN] <= converterEnable;
          prdata[`GPC_CTRL_START] <= conversionStart;
          prdata[`GPC_CTRL_CONT] <= continuousConvert;
          prdata[`GPC_CTRL_SE] <= singleEnded;
          prdata[`GPC_CTRL_FLAG] <= doneFlag;
          prdata[`GPC_CTRL_MASK] <= irqMask;
          prdata[`GPC_CTRL_DMA] <= dmaEnable;
          prdata[`GPC_CTRL_CH_LO+3:`GPC_CTRL_CH_LO] <= channelSel;
        end
        `GPC_OFS_CTRL2: begin
          prdata[`GPC_CTRL2_ATT_LO+1:`GPC_CTRL2_ATT_LO] <= attenuation;
          prdata[`GPC_CTRL2_NEG_LO+3:`GPC_CTRL2_NEG_LO] <= negChannelSel;
        end
        `GPC_OFS_SETTLE: begin
          prdata[7:0] <= settleDelay;
        end
        `GPC_OFS_RESULT: begin
          prdata[DATA_W-1:0] <= conversionResult;
        end
        `GPC_OFS_FIFO: begin
          // empty buffer reads zero and is not popped
          prdata[DATA_W-1:0] <= fifoOutValid ? fifoOutData : {DATA_W{1'b0}};
        end
        `GPC_OFS_STATUS: begin
          prdata[`GPC_ST_READY] <= converterReady;
          prdata[`GPC_ST_BUSY] <= (state == S_CONV) || (state == S_RELEASE);
          prdata[`GPC_ST_EMPTY] <= ~fifoOutValid;
          prdata[`GPC_ST_FULL] <= ~fifoInReady;
          prdata[`GPC_ST_LVL_LO+FIFO_AW:`GPC_ST_LVL_LO] <= fifoLevel;
        end
        default: begin
          errFlag <= 1'b1;
        end
      endcase
    end
  end
endmodule

// ### test/gpc_adc_ctrl_properties.sv
// Purpose: port checker for the converter control
// Assumes: single clock, rst synchronous active high
// Notes: bound at the foot of this file
`timescale 1ns/100ps
`include "gpc_map.vh"
module gpc_adc_ctrl_properties #(
  parameter DATA_W = 10
) (
  input wire ref_clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire regulatorEnable,
  input wire converterReady,
  input wire convStart,
  input wire convDone,
  input wire [DATA_W-1:0] convData,
  input wire [13:0] posSelect,
  input wire [13:0] negSelect,
  input wire [1:0] inputAttenuation,
  input wire singleEndedSelect,
  input wire irq,
  input wire dmaReq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  wire wrCtl = psel && penable && pwrite && paddr == `GPC_OFS_CTRL;
  wire wrCtl2 = psel && penable && pwrite && paddr == `GPC_OFS_CTRL2;
  ////////////////////////////////////////
  a_apb_no_wait: assert property (psel && penable |-> pready)
    else $error("pready low");
  a_regulator_follows: assert property (wrCtl |=> regulatorEnable == $past(pwdata[0]))
    else $error("regulator mismatch");
  a_atten_field: assert property (wrCtl2 |=> inputAttenuation == $past(pwdata[1:0]))
    else $error("attenuation mismatch");
  a_mode_bit: assert property (wrCtl |=> singleEndedSelect == $past(pwdata[3]))
    else $error("mode mismatch");
  a_channel_decode: assert property (wrCtl |=> posSelect ==
    (($past(pwdata[11:8]) > 4'hd) ? 14'h0 : (14'h1 << $past(pwdata[11:8]))))
    else $error("channel decode wrong");
  a_irq_masked: assert property (wrCtl && !pwdata[5] |=> !irq)
    else $error("irq without mask");
  a_single_no_neg: assert property (singleEndedSelect |-> negSelect == 14'h0)
    else $error("negative input in single-ended");
  a_launch_settled: assert property ($rose(convStart) |-> $past(converterReady))
    else $error("launch before settle");
  a_settle_first: assert property ($rose(regulatorEnable) |-> !converterReady [*3])
    else $error("ready too early");
  a_start_holds: assert property (convStart && !convDone && !wrCtl |=> convStart)
    else $error("start dropped early");
  a_done_ends: assert property ($rose(convDone) |-> ##[1:8] !convStart)
    else $error("done not taken");
  c_conv_done: cover property ($fell(convStart));
  c_irq_up: cover property (irq);
  c_dma_up: cover property (dmaReq && wrCtl);
endmodule
////////////////////////////////////////
bind gpc_adc_ctrl gpc_adc_ctrl_properties #(.DATA_W(DATA_W)) i_props (.ref_clk(ref_clk),
  .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .regulatorEnable(regulatorEnable),
  .converterReady(converterReady), .convStart(convStart), .convDone(convDone),
  .convData(convData), .posSelect(posSelect), .negSelect(negSelect),
  .inputAttenuation(inputAttenuation), .singleEndedSelect(singleEndedSelect), .irq(irq),
  .dmaReq(dmaReq));

// ### test/gpc_core_model.sv
// Purpose: behavioural analog core answering conversion requests
// Assumes: lat of 4 or more clocks from start to done
// Notes: values step by 0x013 from 0x0a5
`timescale 1ns/100ps
module gpc_core_model (
  input wire ref_clk,
  input wire convStart,
  input wire [3:0] lat,
  output reg convDone,
  output reg [9:0] convData
);
  reg [9:0] nextVal;
  reg [3:0] cnt;
  initial begin
    convDone = 1'b0;
    convData = 10'h155;
    nextVal = 10'h0a5;
    cnt = 4'h0;
  end
  always @(posedge ref_clk) begin
    if (!convStart) begin
      // released data is not held, so a late sample shows garbage
      if (convDone) convData <= ~convData;
      convDone <= 1'b0;
      cnt <= 4'h0;
    end else if (!convDone) begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'h0) convData <= nextVal;
      if (cnt == lat) begin
        convDone <= 1'b1; // held until start drops
        nextVal <= nextVal + 10'h013;
      end
    end
  end
endmodule

// ### test/gpc_adc_ctrl_test.sv
// Purpose: self-checking bench for the converter control
// Assumes: APB master with one idle cycle between transfers
// Notes: core model answers each launch
`timescale 1ns/100ps
`include "gpc_map.vh"
module gpc_adc_ctrl_test;
  reg ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0, rd;
  reg [3:0] lat = 4'hf;
  reg er;
  integer nErrors = 0, totalChecks = 0, i;
  wire [31:0] prdata;
  wire [13:0] posSelect, negSelect;
  wire [1:0] inputAttenuation;
  wire [9:0] convData;
  wire pready, pslverr, regulatorEnable, converterReady, convStart, convDone;
  wire singleEndedSelect, irq, dmaReq;
  always #20 ref_clk = ~ref_clk;
  gpc_adc_ctrl i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .regulatorEnable(regulatorEnable), .converterReady(converterReady),
    .convStart(convStart), .convDone(convDone), .convData(convData), .posSelect(posSelect),
    .negSelect(negSelect), .inputAttenuation(inputAttenuation),
    .singleEndedSelect(singleEndedSelect), .irq(irq), .dmaReq(dmaReq));
  gpc_core_model i_core (.ref_clk(ref_clk), .convStart(convStart), .lat(lat),
    .convDone(convDone), .convData(convData));
  ////////////////////////////////////////
  task giveVerdict;
    begin
      $display("checks %0d errors %0d", totalChecks, nErrors);
      if (nErrors == 0 && totalChecks > 0) begin
        $display("Regression OK");
      end else begin
        $display("Regression broken");
      end
      $finish;
    end
  endtask
  task chk(input [31:0] g, input [31:0] e);
    begin
      totalChecks = totalChecks + 1;
      if (g !== e) begin
        nErrors = nErrors + 1;
        $display("wrong value at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task rw(input [11:0] a, input w, input [31:0] d);
    integer n;
    begin
      @(posedge ref_clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n < 20) begin
        @(posedge ref_clk);
        n = n + 1;
      end
      chk(n < 20, 1);
      if (n == 20) giveVerdict;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge ref_clk);
    end
  endtask
  // polling is slow but assumes no latency beyond 400 repeated reads
  task poll(input [11:0] a, input [31:0] m, input [31:0] w);
    integer n;
    begin
      n = 0;
      rw(a, 1'b0, 32'h0);
      while ((rd & m) !== w && n < 400) begin
        rw(a, 1'b0, 32'h0);
        n = n + 1;
      end
      chk(n < 400, 1);
      if (n == 400) giveVerdict;
    end
  endtask
  function [31:0] ex(input integer k);
    ex = {22'h0, 10'h0a5 + k[9:0] * 10'h013};
  endfunction
  ////////////////////////////////////////
  task sReset;
    begin
      chk(posSelect, 32'h1);
      rw(`GPC_OFS_SETTLE, 1'b0, 32'h0);
      chk(rd, 32'h40);
      rw(`GPC_OFS_STATUS, 1'b0, 32'h0);
      chk(rd, 32'h4);
      rw(12'h020, 1'b0, 32'h0);
      chk(er, 1);
      chk(rd, 0);
    end
  endtask
  task sModes;
    begin
      for (i = 0; i < 4; i = i + 1) begin
        rw(`GPC_OFS_CTRL2, 1'b1, i);
        chk(inputAttenuation, i);
      end
      for (i = 0; i < 16; i = i + 1) begin
        rw(`GPC_OFS_CTRL, 1'b1, (i << 8) | 8);
        chk(posSelect, i < 14 ? (1 << i) : 0);
        chk(singleEndedSelect, 1);
      end
      rw(`GPC_OFS_CTRL2, 1'b1, 32'hc0);
      rw(`GPC_OFS_CTRL, 1'b1, 32'h500);
      chk({singleEndedSelect, negSelect}, 32'h1000);
      rw(`GPC_OFS_CTRL2, 1'b1, 32'h30);
      rw(`GPC_OFS_CTRL, 1'b1, 32'h200);
      chk({posSelect, negSelect}, 32'h10008);
    end
  endtask
  task sSingle;
    begin
      rw(`GPC_OFS_SETTLE, 1'b1, 32'h2);
      rw(`GPC_OFS_CTRL, 1'b1, 32'h1);
      chk(regulatorEnable, 1);
      rw(`GPC_OFS_STATUS, 1'b0, 32'h0);
      chk(rd & 1, 0);
      poll(`GPC_OFS_STATUS, 32'h1, 32'h1);
      chk(converterReady, 1);
      rw(`GPC_OFS_CTRL, 1'b1, 32'h23);
      rw(`GPC_OFS_CTRL, 1'b1, 32'h23);
      rw(`GPC_OFS_CTRL, 1'b0, 32'h0);
      chk(rd & 2, 2);
      chk(convStart, 1);
      poll(`GPC_OFS_CTRL, 32'h12, 32'h10);
      chk(irq, 1);
      rw(`GPC_OFS_RESULT, 1'b0, 32'h0);
      chk(rd, ex(0));
      rw(`GPC_OFS_STATUS, 1'b0, 32'h0);
      chk(rd & 32'hf0, 32'h10);
      rw(`GPC_OFS_CTRL, 1'b1, 32'h1);
      chk({irq, rd[4]}, 1);
      rw(`GPC_OFS_CTRL, 1'b1, 32'h31);
      chk(irq, 0);
      rw(`GPC_OFS_FIFO, 1'b0, 32'h0);
      chk(rd, ex(0));
    end
  endtask
  task sCont;
    begin
      lat <= 4'h4;
      rw(`GPC_OFS_CTRL, 1'b1, 32'h47);
      poll(`GPC_OFS_STATUS, 32'h8, 32'h8);
      chk(dmaReq, 1);
      rw(`GPC_OFS_RESULT, 1'b0, 32'h0);
      chk(rd, ex(8));
      rw(`GPC_OFS_CTRL, 1'b1, 32'h40);
      for (i = 1; i < 9; i = i + 1) begin
        rw(`GPC_OFS_FIFO, 1'b0, 32'h0);
        chk(rd, ex(i));
      end
      chk(dmaReq, 0);
    end
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    sReset;
    sModes;
    sSingle;
    sCont;
    giveVerdict;
  end
endmodule
